// ---- hw/asmf_pkg.sv ----
// Constants and types shared by the altitude serial message framer.
// Assumes a single 250 MHz clock and software access over APB.
package asmf_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int LORAN_BPS = 1200;
  localparam int ONEFT_BPS = 9600;
  localparam int BAUD_LORAN_CYC = CLK_HZ / LORAN_BPS;
  localparam int BAUD_ONEFT_CYC = CLK_HZ / ONEFT_BPS;
  localparam int SELFTEST_MS = 3000;
  localparam int FRAME_MS = 1000;
  localparam int SELFTEST_CYC = (CLK_HZ / 1000) * SELFTEST_MS;
  localparam int FRAME_CYC = (CLK_HZ / 1000) * FRAME_MS;

  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] ALT_OFF = 12'h008;
  localparam int CTRL_SW_EN = 0;
  localparam int CTRL_ONEFT = 1;
  localparam int CTRL_RES10 = 2;
  localparam int CTRL_CFG = 3;
  localparam int CTRL_SEC_MUTE = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam int ST_DONE = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_STRAPS = 2;
  localparam int ST_RX = 3;

  localparam logic [4:0] LAST_BYTE = 5'h10;
  localparam logic [4:0] CK_FIRST = 5'h0e;
  localparam logic [3:0] TX_BITS = 4'hb;
  localparam int ALT_BIAS = 2000;
  localparam int PAR_OFFSET = 50;
  localparam int STEP10 = 10;
  localparam int STEP100 = 100;
  localparam int DIGITS_MAX = 99999;
  localparam int PAR_BITS = 11;

  typedef enum logic [2:0] {
    ASMF_IDLE = 3'b001,
    ASMF_LOAD = 3'b010,
    ASMF_WAIT = 3'b100
  } asmf_state_t;
endpackage : asmf_pkg

// ---- hw/asmf_uart_tx.sv ----
// One asynchronous character transmitter, start/stop framed.
// Assumes baud_tick is a one-cycle pulse at the bit rate on the same clock.
`timescale 1ns/1ps
module asmf_uart_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic baud_tick,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic seven_odd,
  output logic line,
  output logic ready
);
  import asmf_pkg::*;

  logic [10:0] shreg;
  logic [3:0] cnt;
  logic ninth;

  // Leading idle bit lets the start bit begin on a tick, so it is full width
  assign ninth = seven_odd ? ~^data[6:0] : data[7]; // [RULE2] [RULE4]
  assign ready = (cnt == 4'h0);
  assign line = shreg[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 11'h7ff;
      cnt <= 4'h0;
    end else if (load && ready) begin
      shreg <= {1'b1, ninth, data[6:0], 1'b0, 1'b1}; // [RULE16]
      cnt <= TX_BITS;
    end else if (baud_tick && cnt != 4'h0) begin
      shreg <= {1'b1, shreg[10:1]};
      cnt <= cnt - 4'h1;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_line_high: assert property (ready |-> line) // [RULE16]
    else $error("line not idle high between characters");
  a_line_holds: assert property (!baud_tick && !(load && ready)
      |=> $stable(line)) // [RULE16]
    else $error("line changed between bit ticks");
  a_load_busy: assert property (load && ready |=> !ready && line) // [RULE16]
    else $error("load did not start a character");
endmodule : asmf_uart_tx

// ---- hw/asmf_framer.sv ----
// Altitude serial message framer: APB registers, self-test sequencing,
// parallel Gray-code output drive and the periodic serial frame.
// Assumes alt_ft comes from sensing logic on pclk, range -2000 to 100000.
// Behaviour
// [RULE1] Loran format: "#AL ", sign, five digits, "T+25", checksum, CR.
// [RULE2] Loran format runs 1200 bit/s, seven data bits, odd parity.
// [RULE3] One-foot format: "RMS ", sign, five digits, "T+55", checksum, CR.
// [RULE4] One-foot format runs 9600 bit/s, eight data bits, no parity.
// [RULE5] Both formats need software selection and both straps open.
// [RULE6] Serial altitude sits fifty feet off the parallel code.
// [RULE7] Parallel code steps fifty feet below each hundred-foot mark.
// [RULE8] Ten-foot serial resolution truncates down to a ten-foot multiple.
// [RULE9] Hundred-foot resolution truncates down to a hundred-foot multiple.
// [RULE10] Parallel outputs driven low for three second self-test.
// [RULE11] Serial frames start by themselves, only after self-test.
// [RULE12] Strobe input never changes serial frame timing or content.
// [RULE13] Strobe low keeps parallel outputs enabled; high releases them.
// [RULE14] Receive line heeded only in configuration mode.
// [RULE15] Installer should pick ten-foot resolution for surveillance use.
// [RULE16] Each character framed with start and stop bits per protocol.
// [RULE17] One complete message about once per second.
// [RULE18] Both serial outputs carry the frame; differential copies primary. Secondary is held high while CTRL_SEC_MUTE is set.
// [RULE19] Digits zero-padded ASCII; checksum uppercase hex of byte sum.
// [RULE20] Altitude latched at frame start for the whole message.
`timescale 1ns/1ps
module asmf_framer #(
  parameter int SELFTEST_CYCLES = asmf_pkg::SELFTEST_CYC,
  parameter int FRAME_CYCLES = asmf_pkg::FRAME_CYC,
  parameter int BAUD_LORAN_CYCLES = asmf_pkg::BAUD_LORAN_CYC,
  parameter int BAUD_ONEFT_CYCLES = asmf_pkg::BAUD_ONEFT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [17:0] alt_ft,
  input wire logic strobe_n_pin,
  input wire logic strap_s_pin,
  input wire logic strap_t_pin,
  input wire logic rx_pin,
  output logic [asmf_pkg::PAR_BITS-1:0] par_out,
  output logic [asmf_pkg::PAR_BITS-1:0] par_oe_n,
  output logic serial_out_primary,
  output logic serial_out_secondary,
  output logic differential_out_pos,
  output logic differential_out_neg
);
  import asmf_pkg::*;

  function automatic logic [19:0] bcd5(input logic [16:0] v);
    logic [36:0] s;
    s = {20'h0_0000, v};
    for (int i = 0; i < 17; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (s[17+4*j +: 4] > 4'h4) begin
          s[17+4*j +: 4] = s[17+4*j +: 4] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[36:17];
  endfunction : bcd5

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    return (n < 4'ha) ? {4'h3, n} : ({4'h0, n} + 8'h37);
  endfunction : hex_chr

  function automatic logic [7:0] frame_chr(input logic [4:0] idx,
      input logic oneft, input logic neg, input logic [19:0] dig,
      input logic [7:0] ck);
    logic [7:0] c;
    c = 8'h0d;
    unique case (idx)
      5'h00: c = oneft ? 8'h52 : 8'h23;
      5'h01: c = oneft ? 8'h4d : 8'h41;
      5'h02: c = oneft ? 8'h53 : 8'h4c;
      5'h03: c = 8'h20;
      5'h04: c = neg ? 8'h2d : 8'h2b;
      5'h05: c = {4'h3, dig[19:16]};
      5'h06: c = {4'h3, dig[15:12]};
      5'h07: c = {4'h3, dig[11:8]};
      5'h08: c = {4'h3, dig[7:4]};
      5'h09: c = {4'h3, dig[3:0]};
      5'h0a: c = 8'h54;
      5'h0b: c = 8'h2b;
      5'h0c: c = oneft ? 8'h35 : 8'h32;
      5'h0d: c = 8'h35;
      5'h0e: c = hex_chr(ck[7:4]);
      5'h0f: c = hex_chr(ck[3:0]);
      default: c = 8'h0d;
    endcase
    return c;
  endfunction : frame_chr

  // Pin synchronisers: stage 0 feeds stage 1 only
  logic [2:0] strb_s, straps_s, strapt_s, rx_s;
  logic par_en, straps_open, rx_lvl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strb_s <= 3'h7;
      straps_s <= 3'h7;
      strapt_s <= 3'h7;
      rx_s <= 3'h7;
    end else begin
      strb_s <= {strb_s[1:0], strobe_n_pin};
      straps_s <= {straps_s[1:0], strap_s_pin};
      strapt_s <= {strapt_s[1:0], strap_t_pin};
      rx_s <= {rx_s[1:0], rx_pin};
    end
  end

  // Levels change only when the two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_en <= 1'b0;
      straps_open <= 1'b0;
      rx_lvl <= 1'b1;
    end else begin
      if (strb_s[1] == strb_s[2]) begin
        par_en <= ~strb_s[2]; // [RULE13]
      end
      if (straps_s[1] == straps_s[2] && strapt_s[1] == strapt_s[2]) begin
        straps_open <= straps_s[2] & strapt_s[2]; // [RULE5]
      end
      if (rx_s[1] == rx_s[2]) begin
        rx_lvl <= rx_s[2];
      end
    end
  end

  // Registers
  logic [4:0] ctrl;
  logic rx_seen;
  logic selftest_done;
  logic frame_active;
  logic signed [19:0] frame_alt;
  logic wr_en, rd_setup, rx_fall;
  logic [31:0] rd_val;
  logic rd_bad;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = psel && penable;
  assign rx_fall = rx_lvl && rx_s[2] == 1'b0 && rx_s[1] == 1'b0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && paddr == CTRL_OFF) begin
      ctrl <= pwdata[4:0];
    end
  end

  // A new falling edge wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_seen <= 1'b0;
    end else if (ctrl[CTRL_CFG] && rx_fall) begin
      rx_seen <= 1'b1; // [RULE14]
    end else if (wr_en && paddr == STATUS_OFF && pwdata[ST_RX]) begin
      rx_seen <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    unique case (paddr)
      CTRL_OFF: rd_val[4:0] = ctrl;
      STATUS_OFF: rd_val[3:0] = {rx_seen, straps_open, frame_active,
                                 selftest_done};
      ALT_OFF: rd_val = {{12{frame_alt[19]}}, frame_alt};
      default: rd_bad = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= rd_bad;
    end
  end

  // Self-test and once-per-second frame timer
  logic [29:0] st_cnt;
  logic [27:0] fr_cnt;
  logic frame_tick;
  assign frame_tick = selftest_done && fr_cnt == 28'(FRAME_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_cnt <= 30'h0000_0000;
      selftest_done <= 1'b0;
    end else if (!selftest_done) begin
      st_cnt <= st_cnt + 30'h1;
      if (st_cnt == 30'(SELFTEST_CYCLES - 1)) begin
        selftest_done <= 1'b1; // [RULE10]
      end
    end
  end

  // Free running from self-test end; strobe is not an input here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_cnt <= 28'h000_0000;
    end else if (selftest_done) begin
      fr_cnt <= frame_tick ? 28'h000_0000 : fr_cnt + 28'h1; // [RULE17] [RULE12]
    end
  end

  // Parallel Gray code, centred band on each hundred-foot step
  logic [19:0] par_biased;
  logic [10:0] par_idx;
  assign par_biased = 20'({{2{alt_ft[17]}}, alt_ft} + 20'(ALT_BIAS)
                      + 20'(PAR_OFFSET)); // [RULE6] [RULE7]
  assign par_idx = 11'(par_biased / 20'(STEP100));
  assign par_out = '0;

  // Open collector: enable low sinks the line; self-test sinks them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_oe_n <= '0;
    end else if (!selftest_done) begin
      par_oe_n <= '0; // [RULE10]
    end else begin
      par_oe_n <= par_en ? ~(par_idx ^ (par_idx >> 1)) : '1; // [RULE13]
    end
  end

  // Serial altitude with selected truncation
  logic [19:0] ser_biased, q10, q100, q_sel;
  logic frame_oneft;
  assign ser_biased = 20'({{2{alt_ft[17]}}, alt_ft} + 20'(ALT_BIAS));
  assign q10 = 20'((ser_biased / 20'(STEP10)) * 20'(STEP10)); // [RULE8]
  assign q100 = 20'((ser_biased / 20'(STEP100)) * 20'(STEP100)); // [RULE9]
  assign q_sel = ctrl[CTRL_ONEFT] ? ser_biased
               : (ctrl[CTRL_RES10] ? q10 : q100);

  // Frame sequencer
  asmf_state_t state;
  logic [4:0] byte_idx;
  logic [7:0] ck;
  logic [7:0] cur_byte;
  logic [19:0] mag, digits;
  logic neg, tx_ready, tx_load, tx_line, start_frame, baud_tick;
  logic [17:0] baud_cnt;

  assign neg = frame_alt[19];
  assign mag = neg ? 20'(-frame_alt) : frame_alt;
  assign digits = bcd5((mag > 20'(DIGITS_MAX)) ? 17'(DIGITS_MAX)
                       : mag[16:0]); // [RULE19]
  assign cur_byte = frame_chr(byte_idx, frame_oneft, neg, digits, ck); // [RULE1] [RULE3]
  assign start_frame = state == ASMF_IDLE && frame_tick
                       && ctrl[CTRL_SW_EN] && straps_open; // [RULE5] [RULE11]
  assign tx_load = state == ASMF_LOAD && tx_ready;
  assign frame_active = state != ASMF_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ASMF_IDLE;
      byte_idx <= 5'h00;
      ck <= 8'h00;
      frame_alt <= 20'sh0_0000;
      frame_oneft <= 1'b0;
    end else begin
      unique case (state)
        ASMF_IDLE: begin
          if (start_frame) begin
            frame_alt <= 20'(q_sel - 20'(ALT_BIAS)); // [RULE20]
            frame_oneft <= ctrl[CTRL_ONEFT];
            byte_idx <= 5'h00;
            ck <= 8'h00;
            state <= ASMF_LOAD;
          end
        end
        ASMF_LOAD: begin
          if (tx_ready) begin
            if (byte_idx < CK_FIRST) begin
              ck <= ck + cur_byte; // [RULE19]
            end
            state <= ASMF_WAIT;
          end
        end
        ASMF_WAIT: begin
          if (tx_ready) begin
            if (byte_idx == LAST_BYTE) begin
              state <= ASMF_IDLE; // [RULE1] [RULE3]
            end else begin
              byte_idx <= byte_idx + 5'h01;
              state <= ASMF_LOAD;
            end
          end
        end
      endcase
    end
  end

  // Bit-rate divider; rate fixed per frame so a mid-frame write is harmless
  // Compare with >= so a rate switch above the new limit cannot run away
  assign baud_tick = baud_cnt >= 18'(frame_oneft ? BAUD_ONEFT_CYCLES - 1
                                     : BAUD_LORAN_CYCLES - 1); // [RULE2] [RULE4]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt <= 18'h0_0000;
    end else begin
      baud_cnt <= baud_tick ? 18'h0_0000 : baud_cnt + 18'h1;
    end
  end

  asmf_uart_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .baud_tick(baud_tick),
    .load(tx_load),
    .data(cur_byte),
    .seven_odd(~frame_oneft),
    .line(tx_line),
    .ready(tx_ready)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_primary <= 1'b1;
      serial_out_secondary <= 1'b1;
      differential_out_pos <= 1'b1;
      differential_out_neg <= 1'b0;
    end else begin
      serial_out_primary <= tx_line; // [RULE18]
      serial_out_secondary <= tx_line | ctrl[CTRL_SEC_MUTE];
      differential_out_pos <= tx_line;
      differential_out_neg <= ~tx_line;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_loaded;
    state == ASMF_LOAD && tx_ready && byte_idx == LAST_BYTE;
  endsequence

  a_selftest_low: assert property (!selftest_done |=> par_oe_n == '0) // [RULE10]
    else $error("parallel outputs not all low during self-test");
  a_no_early_tx: assert property (!selftest_done |-> state == ASMF_IDLE
      && serial_out_primary) // [RULE11]
    else $error("serial activity before self-test end");
  a_strap_gate: assert property (start_frame |-> straps_open
      && ctrl[CTRL_SW_EN]) // [RULE5]
    else $error("frame started without software and open straps");
  a_par_release: assert property (selftest_done && !par_en
      |=> par_oe_n == '1) // [RULE13]
    else $error("parallel outputs driven while strobe disabled");
  a_diff_copy: assert property (differential_out_pos == serial_out_primary
      && differential_out_neg != serial_out_primary) // [RULE18]
    else $error("differential pair does not follow primary");
  a_sec_copy: assert property (!$past(ctrl[CTRL_SEC_MUTE])
      |-> serial_out_secondary == serial_out_primary) // [RULE18]
    else $error("secondary output differs from primary");
  a_alt_latched: assert property (frame_active && $past(frame_active)
      |-> $stable(frame_alt)) // [RULE20]
    else $error("altitude changed within a frame");
  a_cr_last: assert property (s_last_loaded |-> cur_byte == 8'h0d
      ##1 state == ASMF_WAIT) // [RULE1] [RULE3]
    else $error("last byte of frame is not carriage return");
  a_rx_ignored: assert property (!ctrl[CTRL_CFG] && !rx_seen
      |=> !rx_seen) // [RULE14]
    else $error("receive activity recorded outside configuration");
  a_frame_tick: assert property (start_frame |-> fr_cnt
      == 28'(FRAME_CYCLES - 1) ##1 fr_cnt == 28'h000_0000) // [RULE17]
    else $error("frame not aligned to the once per second tick");
endmodule : asmf_framer

// ---- verification/asmf_rx_model.sv ----
// Receiver model for the serial altitude line: start/stop decoder that
// queues each character with a flag for good stop bit and parity.
// Assumes the bench sets bit time and character mode between frames.
`timescale 1ns/1ps
module asmf_rx_model (
  input wire logic clk,
  input wire logic line,
  input wire logic seven_odd,
  input wire logic [7:0] bit_cyc
);
  logic [8:0] rxq[$];
  int tq[$];
  int cyc = 0;

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // Samples mid-bit on the falling edge, away from the launching edge
  always begin : rx
    logic [8:0] b;
    logic [7:0] d;
    logic ok;
    @(negedge clk);
    if (line === 1'b0) begin
      tq.push_back(cyc);
      repeat (bit_cyc / 2) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc) @(negedge clk);
        b[i] = line;
      end
      d = seven_odd ? {1'b0, b[6:0]} : b[7:0];
      ok = (b[8] === 1'b1) && (!seven_odd || ^b[7:0] === 1'b1);
      rxq.push_back({ok, d});
    end
  end
endmodule : asmf_rx_model

// ---- verification/tb.sv ----
// Bench for the altitude serial message framer: APB set-up, decoded
// frames, parallel code, strobe, straps and self-test.
// Assumes shortened self-test, frame and bit-time parameters.
`timescale 1ns/1ps
module tb;
  import asmf_pkg::*;
  localparam int FR = 8000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [17:0] alt_ft = 18'h0_035b;
  logic strobe_n_pin = 1'b0;
  logic strap_s_pin = 1'b1;
  logic strap_t_pin = 1'b1;
  logic rx_pin = 1'b1;
  logic [PAR_BITS-1:0] par_out;
  logic [PAR_BITS-1:0] par_oe_n;
  logic serial_out_primary;
  logic serial_out_secondary;
  logic differential_out_pos;
  logic differential_out_neg;
  logic seven_odd = 1'b1;
  logic [7:0] bcyc = 8'h10;
  logic copy_bad = 1'b0;
  logic [31:0] rd;
  logic er;
  int fail_count = 0;
  int n_compared = 0;

  always #2 pclk = ~pclk;

  asmf_framer #(.SELFTEST_CYCLES(200), .FRAME_CYCLES(FR),
    .BAUD_LORAN_CYCLES(16), .BAUD_ONEFT_CYCLES(4)) i_asmf_framer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alt_ft(alt_ft),
    .strobe_n_pin(strobe_n_pin), .strap_s_pin(strap_s_pin),
    .strap_t_pin(strap_t_pin), .rx_pin(rx_pin), .par_out(par_out),
    .par_oe_n(par_oe_n), .serial_out_primary(serial_out_primary),
    .serial_out_secondary(serial_out_secondary),
    .differential_out_pos(differential_out_pos),
    .differential_out_neg(differential_out_neg));

  asmf_rx_model i_asmf_rx_model (.clk(pclk), .line(serial_out_primary),
    .seven_odd(seven_odd), .bit_cyc(bcyc));

  always @(posedge pclk) begin
    if (presetn && (serial_out_secondary !== serial_out_primary ||
        differential_out_pos !== serial_out_primary ||
        differential_out_neg !== ~serial_out_primary)) begin
      copy_bad <= 1'b1;
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (pready !== 1'b1 && k >= 20) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : apb

  task automatic set_alt(int a);
    alt_ft <= 18'(a);
  endtask : set_alt

  function automatic logic [10:0] gray(int a);
    int i;
    i = (a + 2050) / 100;
    return 11'(i ^ (i >> 1));
  endfunction : gray

  function automatic string hx(int v);
    string h;
    h = "0123456789ABCDEF";
    return h.substr(v, v);
  endfunction : hx

  function automatic string frame_of(string pre, int a, string t);
    string s;
    int ck;
    s = $sformatf("%s%s%05dT+%s", pre, (a < 0) ? "-" : "+",
      (a < 0) ? -a : a, t);
    ck = 0;
    foreach (s[i]) ck += s[i];
    ck = ck % 256;
    return {s, hx(ck / 16), hx(ck % 16), "\r"};
  endfunction : frame_of

  task automatic flush();
    i_asmf_rx_model.rxq.delete();
    i_asmf_rx_model.tq.delete();
  endtask : flush

  task automatic wait_bytes(int n);
    int k;
    k = 0;
    while (i_asmf_rx_model.rxq.size() < n && k < 3 * FR) begin
      @(posedge pclk);
      k++;
    end
    if (i_asmf_rx_model.rxq.size() < n) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : wait_bytes

  task automatic recv(string s);
    wait_bytes(17);
    for (int i = 0; i < 17; i++) begin
      chk("frame byte", s[i], i_asmf_rx_model.rxq[i][7:0]);
      chk("char framing", 1, i_asmf_rx_model.rxq[i][8]);
    end
  endtask : recv

  task automatic s_selftest();
    logic bad;
    bad = 1'b0;
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    repeat (150) begin
      @(posedge pclk);
      if (par_oe_n !== '0 || serial_out_primary !== 1'b1) bad = 1'b1;
    end
    chk("self-test hold", 0, bad);
    repeat (100) @(posedge pclk);
    chk("parallel code", 11'(~gray(859)), par_oe_n);
    chk("parallel sink value", 0, par_out);
    set_alt(10949);
    repeat (4) @(posedge pclk);
    chk("parallel low band", 11'(~gray(10949)), par_oe_n);
    set_alt(10950);
    repeat (4) @(posedge pclk);
    chk("parallel step", 11'(~gray(10950)), par_oe_n);
    strobe_n_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("parallel released", 32'h0000_07ff, par_oe_n);
    strobe_n_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("parallel enabled", 11'(~gray(10950)), par_oe_n);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk("status", 32'h0000_0005, rd);
    apb(1'b0, CTRL_OFF, 32'h0000_0000);
    chk("ctrl readback", 32'h0000_0001, rd);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk("unmapped error", 1, er);
  endtask : s_selftest

  task automatic s_loran();
    set_alt(-1234);
    flush();
    recv(frame_of("#AL ", -1300, "25"));
    apb(1'b1, CTRL_OFF, 32'h0000_0005);
    set_alt(11009);
    flush();
    fork
      recv(frame_of("#AL ", 11000, "25"));
      begin
        wait_bytes(3);
        set_alt(500);
      end
    join
  endtask : s_loran

  task automatic s_oneft();
    int t;
    int d;
    apb(1'b1, CTRL_OFF, 32'h0000_0003);
    set_alt(859);
    bcyc <= 8'h04;
    seven_odd <= 1'b0;
    flush();
    fork
      recv(frame_of("RMS ", 859, "55"));
      for (int k = 0; k < 3 * FR; k++) begin
        @(posedge pclk);
        if (i_asmf_rx_model.rxq.size() >= 17) break;
        strobe_n_pin <= ~strobe_n_pin;
      end
    join
    strobe_n_pin <= 1'b0;
    t = i_asmf_rx_model.tq[0];
    set_alt(-77);
    flush();
    recv(frame_of("RMS ", -77, "55"));
    d = i_asmf_rx_model.tq[0] - t - FR;
    chk("frame period", 1, d > -7 && d < 7);
  endtask : s_oneft

  task automatic pulse_rx();
    rx_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    rx_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
  endtask : pulse_rx

  task automatic s_rx_straps();
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    pulse_rx();
    chk("rx ignored", 0, rd[3]);
    apb(1'b1, CTRL_OFF, 32'h0000_0008);
    pulse_rx();
    chk("rx seen", 1, rd[3]);
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    strap_s_pin <= 1'b0;
    flush();
    repeat (FR + 500) @(posedge pclk);
    chk("strap blocks frames", 0, i_asmf_rx_model.rxq.size());
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk("straps open flag", 0, rd[2]);
  endtask : s_rx_straps

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_selftest();
    s_loran();
    s_oneft();
    s_rx_straps();
    chk("output copies", 0, copy_bad);
    tally_and_finish();
  end
endmodule : tb
